// ===== hw/core_regs.sv
// working registers, flags, program counter and stack pointer of the core
// ****************************************************************
// ****************************************************************
module core_regs
  import core_regs_pkg::*;
(
  input  wire logic               mclk,              // core clock, 20 MHz
  input  wire logic               rst_n,             // async reset, active low
  input  wire reg_write_t         wr,                // register write from data path
  input  wire flag_ctl_t          fctl,              // flag control from decoder
  input  wire logic               cond_instr,        // conditional jump/call decoded
  input  wire logic               irq_entry,         // interrupt entry: push flags
  input  wire logic               irq_return,        // interrupt return: restore flags
  input  wire saved_flags_t       popped_flags,      // flags read back from stack RAM
  input  wire stack_op_t          stack_op,          // stack push / pop
  input  wire logic               stack_init_clear,  // stack_init_bit cleared by bit-clear op
  input  wire logic               pc_advance,        // step program counter
  input  wire logic               pc_load,           // load program counter
  input  wire logic [PC_W-1:0]    pc_target,         // program counter target
  output reg_view_t               regs,              // registers to ALU and RAM path
  output logic [BANK_W+2*DATA_W-1:0] ram_addr,       // indirect RAM address
  output logic [DATA_W-1:0]       port_bit_sel,      // discrete output bit select
  output logic                    overflow_bit,      // carry / overflow flag
  output logic                    branch_condition_bit, // status flag
  output logic                    branch_taken,      // conditional transfer takes effect
  output saved_flags_t            push_flags,        // flags to stack on interrupt
  output logic                    push_flags_valid,  // push_flags write strobe
  output logic [PC_W-1:0]         pc,                // program counter
  output logic [SP_W-1:0]         sp                 // stack pointer
);

  // ****************************************************************
  // data registers
  // ****************************************************************
  // data registers clear at reset only so that simulation is free of X;
  // software must not rely on that value
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] res2;
  logic [BANK_W-1:0] bank;
  logic [DATA_W-1:0] col;
  logic [DATA_W-1:0] row;
  logic [DATA_W-1:0] aux_col;
  logic [DATA_W-1:0] aux_row;
  logic [DATA_W-1:0] next_acc;
  logic [DATA_W-1:0] next_res2;
  logic [BANK_W-1:0] next_bank;
  logic [DATA_W-1:0] next_col;
  logic [DATA_W-1:0] next_row;
  logic [DATA_W-1:0] next_aux_col;
  logic [DATA_W-1:0] next_aux_row;
  logic              load_acc;
  logic              load_res2;
  logic              load_bank;
  logic              load_col;
  logic              load_row;
  logic              load_aux_col;
  logic              load_aux_row;

  // one destination per cycle; the none code and spare codes write nothing
  always_comb begin
    load_acc     = 1'b0;
    load_res2    = 1'b0;
    load_bank    = 1'b0;
    load_col     = 1'b0;
    load_row     = 1'b0;
    load_aux_col = 1'b0;
    load_aux_row = 1'b0;
    case (wr.dst)
      DST_ACC:  load_acc     = 1'b1;
      DST_RES2: load_res2    = 1'b1;
      DST_BANK: load_bank    = 1'b1;
      DST_COL:  load_col     = 1'b1;
      DST_ROW:  load_row     = 1'b1;
      DST_AUXC: load_aux_col = 1'b1;
      DST_AUXR: load_aux_row = 1'b1;
      default:  load_acc     = 1'b0;
    endcase
  end

  // ****************************************************************
  // accumulator and second result register
  // ****************************************************************
  // accumulator: ALU result and transfer register
  always_comb begin
    next_acc = acc;
    if (load_acc) begin
      next_acc = wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= DATA_CLEAR;
    end else begin
      acc <= next_acc;
    end
  end

  // second result register
  always_comb begin
    next_res2 = res2;
    if (load_res2) begin
      next_res2 = wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res2 <= DATA_CLEAR;
    end else begin
      res2 <= next_res2;
    end
  end

  // ****************************************************************
  // bank and index registers
  // ****************************************************************
  // bank register: top two bits of the indirect address
  always_comb begin
    next_bank = bank;
    if (load_bank) begin
      next_bank = wr.data[BANK_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank <= BANK_CLEAR;
    end else begin
      bank <= next_bank;
    end
  end

  // column index register
  always_comb begin
    next_col = col;
    if (load_col) begin
      next_col = wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      col <= DATA_CLEAR;
    end else begin
      col <= next_col;
    end
  end

  // row index register, also the discrete output bit select
  always_comb begin
    next_row = row;
    if (load_row) begin
      next_row = wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      row <= DATA_CLEAR;
    end else begin
      row <= next_row;
    end
  end

  // ****************************************************************
  // auxiliary index registers
  // ****************************************************************
  // auxiliary column register
  always_comb begin
    next_aux_col = aux_col;
    if (load_aux_col) begin
      next_aux_col = wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux_col <= DATA_CLEAR;
    end else begin
      aux_col <= next_aux_col;
    end
  end

  // auxiliary row register
  always_comb begin
    next_aux_row = aux_row;
    if (load_aux_row) begin
      next_aux_row = wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux_row <= DATA_CLEAR;
    end else begin
      aux_row <= next_aux_row;
    end
  end

  // ****************************************************************
  // register view and indirect address
  // ****************************************************************
  // the view is wiring only; every bit of it leaves one of the flops above
  assign regs = '{acc: acc, res2: res2, bank: bank, col: col, row: row,
                  aux_col: aux_col, aux_row: aux_row};

  // address outputs use the look-ahead values so they change on the same
  // edge as the registers they are built from
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ram_addr <= '0;
    end else begin
      ram_addr <= {next_bank, next_col, next_row};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_bit_sel <= DATA_CLEAR;
    end else begin
      port_bit_sel <= next_row;
    end
  end

  // ****************************************************************
  // overflow flag
  // ****************************************************************
  logic next_overflow;

  // a restore from the stack outranks any flag operation in the same cycle
  always_comb begin
    next_overflow = overflow_bit;
    if (irq_return) begin
      next_overflow = popped_flags.overflow;
    end else begin
      case (fctl.ovf_op)
        FOP_SET:    next_overflow = 1'b1;
        FOP_CLEAR:  next_overflow = 1'b0;
        FOP_ARITH:  next_overflow = fctl.alu_carry;
        FOP_ROTATE: next_overflow = fctl.rot_carry;
        default:    next_overflow = overflow_bit;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_bit <= 1'b0;
    end else begin
      overflow_bit <= next_overflow;
    end
  end

  // ****************************************************************
  // branch condition flag
  // ****************************************************************
  // a conditional fetch wins over a same-cycle latch: the fetch leaves the
  // flag high for the next test unless an irq_return restores it that cycle
  logic next_branch_cond;

  always_comb begin
    next_branch_cond = branch_condition_bit;
    if (irq_return) begin
      next_branch_cond = popped_flags.branch_cond;
    end else if (cond_instr) begin
      next_branch_cond = 1'b1;
    end else if (fctl.cond_load) begin
      next_branch_cond = fctl.cond_value;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      branch_condition_bit <= BCOND_RESET;
    end else begin
      branch_condition_bit <= next_branch_cond;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      branch_taken <= 1'b0;
    end else begin
      branch_taken <= cond_instr & branch_condition_bit;
    end
  end

  // ****************************************************************
  // interrupt flag save
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      push_flags_valid <= 1'b0;
    end else begin
      push_flags_valid <= irq_entry;
    end
  end

  // the saved pair holds its last value between entries
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      push_flags <= '0;
    end else if (irq_entry) begin
      push_flags <= '{overflow: overflow_bit,
                      branch_cond: branch_condition_bit};
    end
  end

  // ****************************************************************
  // program counter and stack pointer
  // ****************************************************************
  prog_counter u_pc (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .advance (pc_advance),
    .load    (pc_load),
    .target  (pc_target),
    .pc      (pc)
  );

  stack_ptr u_sp (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .op     (stack_op),
    .reinit (stack_init_clear),
    .sp     (sp)
  );

endmodule : core_regs

// ===== hw/core_regs_pkg.sv
// shared constants and carrier types for the core working-register set
package core_regs_pkg;

  localparam int          DATA_W        = 4;
  localparam int          BANK_W        = 2;
  localparam int          PC_W          = 14;
  localparam int          SP_W          = 10;
  localparam int          SP_FIXED_W    = 4;
  localparam logic [13:0] PC_RESET      = 14'h0000;
  localparam logic [9:0]  SP_RESET      = 10'h3FF;
  localparam logic [9:0]  SP_STEP       = 10'h004;
  localparam logic [3:0]  SP_TOP_FIXED  = 4'hF;
  localparam logic        BCOND_RESET   = 1'b1;
  localparam logic [3:0]  DATA_CLEAR    = 4'h0;
  localparam logic [1:0]  BANK_CLEAR    = 2'h0;

  // destination select for register writes from the ALU / data path
  typedef enum logic [3:0] {
    DST_NONE  = 4'h0,
    DST_ACC   = 4'h1,
    DST_RES2  = 4'h2,
    DST_BANK  = 4'h3,
    DST_COL   = 4'h4,
    DST_ROW   = 4'h5,
    DST_AUXC  = 4'h6,
    DST_AUXR  = 4'h7
  } dst_sel_t;

  // flag operations decoded from the instruction
  typedef enum logic [2:0] {
    FOP_NONE      = 3'h0,
    FOP_SET       = 3'h1,
    FOP_CLEAR     = 3'h2,
    FOP_ARITH     = 3'h3,
    FOP_ROTATE    = 3'h4
  } flag_op_t;

  // stack operation encoding
  typedef enum logic [1:0] {
    STK_NONE = 2'h0,
    STK_PUSH = 2'h1,
    STK_POP  = 2'h2
  } stack_op_t;

  typedef struct packed {
    dst_sel_t           dst;
    logic [DATA_W-1:0]  data;
  } reg_write_t;

  typedef struct packed {
    flag_op_t  ovf_op;
    logic      alu_carry;
    logic      rot_carry;
    logic      cond_load;
    logic      cond_value;
    logic      cond_branch_fetch;
  } flag_ctl_t;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] res2;
    logic [BANK_W-1:0] bank;
    logic [DATA_W-1:0] col;
    logic [DATA_W-1:0] row;
    logic [DATA_W-1:0] aux_col;
    logic [DATA_W-1:0] aux_row;
  } reg_view_t;

  typedef struct packed {
    logic overflow;
    logic branch_cond;
  } saved_flags_t;

endpackage : core_regs_pkg

// ===== hw/stack_ptr.sv
// ten-bit stack pointer with fixed upper bits
module stack_ptr
  import core_regs_pkg::*;
(
  input  wire logic            mclk,      // core clock
  input  wire logic            rst_n,     // async reset, active low
  input  wire stack_op_t       op,        // push / pop / none
  input  wire logic            reinit,    // stack-initialise bit cleared
  output logic [SP_W-1:0]      sp         // next free stack slot
);

  logic [SP_W-SP_FIXED_W-1:0] low;

  // only the low six bits are state; the top four never move
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low <= SP_RESET[SP_W-SP_FIXED_W-1:0];
    end else if (reinit) begin
      low <= SP_RESET[SP_W-SP_FIXED_W-1:0];
    end else if (op == STK_PUSH) begin
      low <= low - SP_STEP[SP_W-SP_FIXED_W-1:0];
    end else if (op == STK_POP) begin
      low <= low + SP_STEP[SP_W-SP_FIXED_W-1:0];
    end
  end

  assign sp = {SP_TOP_FIXED, low};

endmodule : stack_ptr

// ===== hw/prog_counter.sv
// fourteen-bit program counter
module prog_counter
  import core_regs_pkg::*;
(
  input  wire logic            mclk,      // core clock
  input  wire logic            rst_n,     // async reset, active low
  input  wire logic            advance,   // step to next instruction
  input  wire logic            load,      // jump / call / return
  input  wire logic [PC_W-1:0] target,    // jump target
  output logic [PC_W-1:0]      pc         // address of executing instruction
);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_RESET;
    end else if (load) begin
      pc <= target;
    end else if (advance) begin
      pc <= pc + 14'h0001;
    end
  end

endmodule : prog_counter

// ===== bench/core_regs_properties.sv
// concurrent checks on the core register set ports
// ****************************************************************
// port checker
// ****************************************************************
module core_regs_properties
  import core_regs_pkg::*;
(
  input wire logic         mclk,                 // core clock
  input wire logic         rst_n,                // reset, active low
  input wire reg_write_t   wr,                   // register write
  input wire flag_ctl_t    fctl,                 // flag control
  input wire logic         cond_instr,           // conditional fetch
  input wire logic         irq_return,           // interrupt return
  input wire saved_flags_t popped_flags,         // flags from stack
  input wire stack_op_t    stack_op,             // push or pop
  input wire logic         stack_init_clear,     // stack reload
  input wire reg_view_t    regs,                 // register view
  input wire logic [9:0]   ram_addr,             // indirect address
  input wire logic [3:0]   port_bit_sel,         // output bit select
  input wire logic         overflow_bit,         // carry flag
  input wire logic         branch_condition_bit, // status flag
  input wire logic         branch_taken,         // transfer taken
  input wire logic [9:0]   sp                    // stack pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_cond_fetch;
    cond_instr && !irq_return;
  endsequence
  sequence s_push;
    stack_op == STK_PUSH && !stack_init_clear;
  endsequence
  a_acc_write: assert property (
    wr.dst == DST_ACC |=> regs.acc == $past(wr.data)) else $error("acc write lost");
  a_addr_concat: assert property (
    ram_addr == {regs.bank, regs.col, regs.row}) else $error("ram address wrong");
  a_port_select: assert property (port_bit_sel == regs.row)
    else $error("port bit select wrong");
  a_ovf_arith: assert property (
    fctl.ovf_op == FOP_ARITH && !irq_return |=> overflow_bit == $past(fctl.alu_carry))
    else $error("carry not captured");
  a_ovf_set_clear: assert property (
    (fctl.ovf_op == FOP_SET || fctl.ovf_op == FOP_CLEAR) && !irq_return
    |=> overflow_bit == ($past(fctl.ovf_op) == FOP_SET)) else $error("set or clear failed");
  a_flag_restore: assert property (
    irq_return |=> {overflow_bit, branch_condition_bit} == $past(popped_flags))
    else $error("flags not restored");
  a_cond_force: assert property (
    s_cond_fetch |=> branch_condition_bit && branch_taken == $past(branch_condition_bit))
    else $error("conditional fetch mishandled");
  a_cond_hold: assert property (
    !cond_instr && !irq_return && !fctl.cond_load |=> $stable(branch_condition_bit))
    else $error("status flag changed");
  a_sp_push: assert property (
    s_push |=> sp[5:0] == $past(sp[5:0]) - 6'h04) else $error("push step wrong");
  a_sp_top: assert property (sp[9:6] == SP_TOP_FIXED)
    else $error("stack top bits changed");
  a_sp_reinit: assert property (stack_init_clear |=> sp == SP_RESET)
    else $error("stack not reloaded");
endmodule : core_regs_properties

// ===== bench/tb.sv
// self-checking random bench for the core register set
module tb
  import core_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    reg_view_t       r;
    logic            o, s, t, v;
    saved_flags_t    f;
    logic [PC_W-1:0] p;
    logic [SP_W-1:0] q;
    logic [9:0]      ad;
    logic [3:0]      ps;
  } obs_t;
  logic mclk, rst_n, cond_instr, irq_entry, irq_return, stack_init_clear, pc_advance, pc_load;
  logic overflow_bit, branch_condition_bit, branch_taken, push_flags_valid;
  reg_write_t wr;
  flag_ctl_t fctl;
  saved_flags_t popped_flags, push_flags;
  stack_op_t stack_op;
  logic [PC_W-1:0] pc_target, pc;
  reg_view_t regs;
  logic [9:0] ram_addr, sp;
  logic [3:0] port_bit_sel;
  obs_t m, n, e, a;
  obs_t exp_q[$];
  int fails, compares, i;
  logic [31:0] seed, r, s;
  core_regs core_regs_inst (.mclk, .rst_n, .wr, .fctl, .cond_instr, .irq_entry, .irq_return,
    .popped_flags, .stack_op, .stack_init_clear, .pc_advance, .pc_load, .pc_target, .regs,
    .ram_addr, .port_bit_sel, .overflow_bit, .branch_condition_bit, .branch_taken,
    .push_flags, .push_flags_valid, .pc, .sp);
  task check(input obs_t got, input obs_t want);
    compares++;
    if (got !== want) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  function automatic obs_t reset_obs();
    obs_t z;
    z = '0;
    z.s = BCOND_RESET;
    z.p = PC_RESET;
    z.q = SP_RESET;
    return z;
  endfunction : reset_obs
  // rare interrupt returns and reloads so flags and stack mostly evolve
  task drive;
    r = $random(seed);
    s = $random(seed);
    wr = '{dst_sel_t'({1'b0, r[2:0]}), r[6:3]};
    fctl = '{flag_op_t'(r[9:7] % 3'h5), r[10], r[11], r[12], r[13], r[14]};
    cond_instr = r[16:15] == 2'h0;
    irq_return = r[19:17] == 3'h0;
    irq_entry = !irq_return && r[22:20] == 3'h1;
    popped_flags = r[24:23];
    stack_op = stack_op_t'(r[26:25] % 2'h3);
    stack_init_clear = r[31:27] == 5'h00;
    pc_advance = s[0];
    pc_load = s[3:1] == 3'h0;
    pc_target = s[17:4];
  endtask : drive
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ****************************************************************
  // reference model: notes one expected snapshot per edge
  // ****************************************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      m = reset_obs();
    end else begin
      n = m;
      n.t = cond_instr & m.s;
      n.v = irq_entry;
      n.f = '{m.o, m.s};
      case (wr.dst)
        DST_ACC:  n.r.acc = wr.data;
        DST_RES2: n.r.res2 = wr.data;
        DST_BANK: n.r.bank = wr.data[1:0];
        DST_COL:  n.r.col = wr.data;
        DST_ROW:  n.r.row = wr.data;
        DST_AUXC: n.r.aux_col = wr.data;
        DST_AUXR: n.r.aux_row = wr.data;
        default: ;
      endcase
      if (irq_return) {n.o, n.s} = popped_flags;
      else begin
        case (fctl.ovf_op)
          FOP_SET:    n.o = 1'b1;
          FOP_CLEAR:  n.o = 1'b0;
          FOP_ARITH:  n.o = fctl.alu_carry;
          FOP_ROTATE: n.o = fctl.rot_carry;
          default: ;
        endcase
        if (cond_instr) n.s = 1'b1;
        else if (fctl.cond_load) n.s = fctl.cond_value;
      end
      n.p = pc_load ? pc_target : m.p + PC_W'(pc_advance);
      if (stack_init_clear) n.q = SP_RESET;
      else if (stack_op == STK_PUSH) n.q[5:0] = m.q[5:0] - 6'h04;
      else if (stack_op == STK_POP) n.q[5:0] = m.q[5:0] + 6'h04;
      n.ad = {n.r.bank, n.r.col, n.r.row};
      n.ps = n.r.row;
      m = n;
    end
    exp_q.push_back(m);
  end
  always @(posedge mclk) begin
    #2;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      // reset acts at once, so a snapshot taken while it is low sees reset values
      if (!rst_n) e = reset_obs();
      e.f = e.f & {2{e.v}};
      a = {regs, overflow_bit, branch_condition_bit, branch_taken, push_flags_valid,
           push_flags & {2{push_flags_valid}}, pc, sp, ram_addr, port_bit_sel};
      check(a, e);
    end
  end
  initial begin
    seed = 32'h2B3410EC;
    rst_n = 1'b0;
    drive();
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (i = 0; i < 1500; i++) begin
      @(posedge mclk);
      #1;
      if (i == 700) rst_n = 1'b0;
      if (i == 702) rst_n = 1'b1;
      drive();
    end
    repeat (2) @(posedge mclk);
    #3 final_report();
  end
  initial begin
    #(2000 * 50);
    fails++;
    final_report();
  end
endmodule : tb
bind core_regs core_regs_properties core_regs_properties_inst (.mclk, .rst_n, .wr, .fctl,
  .cond_instr, .irq_return, .popped_flags, .stack_op, .stack_init_clear, .regs, .ram_addr,
  .port_bit_sel, .overflow_bit, .branch_condition_bit, .branch_taken, .sp);
